// ### hw/lpss_consts.svh
// Timing counts and mode encodings for the low-power standby/halt sequencer
`ifndef LPSS_CONSTS_SVH
`define LPSS_CONSTS_SVH

`define LPSS_MODE_STANDBY   2'h1
`define LPSS_MODE_IDLE      2'h0
`define LPSS_DRAIN_SHORT    7'h20
`define LPSS_DRAIN_LONG     7'h40
`define LPSS_XCLK_CYCLES    7'h20
`define LPSS_QUAL_BASE      7'h02
`define LPSS_QUAL_PLAIN     7'h03
`define LPSS_RESUME_CYCLES  7'h04
`define LPSS_LOCK_CYCLES    131072
`define LPSS_STBY_WAKE_MAX  100
`define LPSS_HALT_WAKE_MAX  35

`endif

// ### hw/lpss_pkg.sv
// Types shared by the low-power standby/halt sequencer
package lpss_pkg;
    typedef enum logic [2:0] {
        LPSS_RUN,
        LPSS_DRAIN,
        LPSS_STANDBY,
        LPSS_HALT,
        LPSS_OSC_WAIT,
        LPSS_LOCK,
        LPSS_RESUME
    } lpss_state_t;
endpackage

// ### hw/lpss_sequencer.sv
// Low-power standby/halt entry and wake sequencer
// Summary of operation
// - IDLE with standby selected starts standby entry
// - Drain system clock 32 or 64 cycles
// - Standby gates peripheral clocks, keeps PLL running
// - External clock low 32 to 45 cycles
// - Standby wake needs 2 plus count cycles
// - Standby wake to resume within 100 cycles
// - Latency measured to instruction after IDLE
// - Resume, with wake interrupt request in the same cycle if enabled
// - IDLE with halt selected stops core clock
// - Halt stops peripheral clocks and PLL too
// - Halt stops oscillator when crystal source used
// - Halt wake pin falling edge restarts oscillator
// - Wait 131072 oscillator cycles for PLL lock
// - Lock to resume within 35 cycles
// - After lock re-enable clocks; halt is left at the wake, before lock
`include "lpss_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module lpss_sequencer #(
    parameter int LOCK_CYCLES = `LPSS_LOCK_CYCLES,
    parameter int QUAL_W      = 6
) (
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    input  wire logic              idle_exec_i,
    input  wire logic [1:0]        low_power_ctrl_word_i,
    input  wire logic              input_clock_halving_i,
    input  wire logic [QUAL_W-1:0] standby_wake_qual_count_i,
    input  wire logic              standby_qual_en_i,
    input  wire logic              crystal_source_i,
    input  wire logic              wake_int_enable_i,
    input  wire logic              standby_wake_n_i,
    input  wire logic              halt_wake_pin_i,
    input  wire logic              external_reset_pin_n_i,
    input  wire logic              osc_stable_i,
    output logic                   system_clock_en_o,
    output logic                   core_clock_en_o,
    output logic                   periph_clock_en_o,
    output logic                   external_clock_output_en_o,
    output logic                   pll_power_en_o,
    output logic                   osc_enable_o,
    output logic                   resume_exec_o,
    output logic                   wake_isr_req_o,
    output logic                   standby_o,
    output logic                   halt_o
);
    import lpss_pkg::*;

    localparam int RES_MAX_STBY = `LPSS_STBY_WAKE_MAX;
    localparam int RES_MAX_HALT = `LPSS_HALT_WAKE_MAX;

    lpss_state_t       state_q, state_d;
    logic [6:0]        cnt_q, cnt_d;
    logic [17:0]       lock_cnt_q, lock_cnt_d;
    logic [6:0]        qual_cnt_q, qual_cnt_d;
    logic              halt_sel_q, halving_q;
    logic [3:0]        sw_s1_q, sw_s2_q;
    logic              halt_pin_d3_q;
    logic              sys_en_q, core_en_q, periph_en_q, xclk_en_q, pll_en_q, osc_en_q;
    logic              resume_q, isr_q;
    logic              stby_q, halt_q;

    // Pin inputs pass two flops; the first stage feeds only the second
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            // Idle-high so no wake and no pin edge is seen just after reset
            sw_s1_q <= 4'hF;
            sw_s2_q <= 4'hF;
            halt_pin_d3_q <= 1'b1;
        end else begin
            sw_s1_q <= {osc_stable_i, external_reset_pin_n_i, halt_wake_pin_i, standby_wake_n_i};
            sw_s2_q <= sw_s1_q;
            halt_pin_d3_q <= sw_s2_q[1];
        end
    end

    // Decodes and selections
    wire        stby_wake_act = !sw_s2_q[0];
    wire        halt_pin_fall = halt_pin_d3_q && !sw_s2_q[1];
    wire        rst_pin_act   = !sw_s2_q[2];
    wire        osc_ok        = sw_s2_q[3];
    wire        lp_selected   = low_power_ctrl_word_i != `LPSS_MODE_IDLE;
    wire        idle_go       = (state_q == LPSS_RUN) && idle_exec_i && lp_selected;
    wire [6:0]  drain_len     = halving_q ? `LPSS_DRAIN_LONG : `LPSS_DRAIN_SHORT;
    wire        drain_done    = (state_q == LPSS_DRAIN) && (cnt_q == drain_len - 7'h01);
    wire [6:0]  qual_thr      = standby_qual_en_i
                                ? (`LPSS_QUAL_BASE + 7'(standby_wake_qual_count_i))
                                : `LPSS_QUAL_PLAIN;
    wire        qual_hit      = qual_cnt_q >= qual_thr;
    wire        halt_wake     = halt_pin_fall || rst_pin_act;
    wire        lock_done     = (state_q == LPSS_LOCK) && (lock_cnt_q == 18'h00000);
    wire        resume_go     = (state_q == LPSS_RESUME) && (cnt_q == `LPSS_RESUME_CYCLES - 7'h01);
    wire        clk_run_d     = (state_d == LPSS_RUN) || (state_d == LPSS_DRAIN) || (state_d == LPSS_RESUME);
    wire        pll_off_d     = (state_d == LPSS_HALT) || (state_d == LPSS_OSC_WAIT);

    // Sequencing; halt wake restarts the oscillator before any lock count runs
    always_comb begin
        state_d = state_q;
        case (state_q)
            LPSS_RUN: begin
                if (idle_go) state_d = LPSS_DRAIN;
            end
            LPSS_DRAIN: begin
                if (drain_done) state_d = halt_sel_q ? LPSS_HALT : LPSS_STANDBY;
            end
            LPSS_STANDBY: begin
                if (qual_hit) state_d = LPSS_RESUME;
            end
            LPSS_HALT: begin
                if (halt_wake) state_d = LPSS_OSC_WAIT;
            end
            LPSS_OSC_WAIT: begin
                if (osc_ok) state_d = LPSS_LOCK;
            end
            LPSS_LOCK: begin
                if (lock_done) state_d = LPSS_RESUME;
            end
            LPSS_RESUME: begin
                if (resume_go) state_d = LPSS_RUN;
            end
            default: state_d = LPSS_RUN;
        endcase
    end

    // Counters: step count restarts on every state change
    assign cnt_d      = (state_d != state_q) ? 7'h00 : cnt_q + 7'h01;
    assign lock_cnt_d = (state_d == LPSS_LOCK && state_q != LPSS_LOCK) ? 18'(LOCK_CYCLES - 1)
                        : (state_q == LPSS_LOCK) ? lock_cnt_q - 18'h00001 : lock_cnt_q;
    // Qualifier saturates so a long-held level cannot wrap back below threshold
    assign qual_cnt_d = (state_q != LPSS_STANDBY || !stby_wake_act) ? 7'h00
                        : (qual_cnt_q == 7'h7F) ? qual_cnt_q : qual_cnt_q + 7'h01;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_q    <= LPSS_RUN;
            cnt_q      <= 7'h00;
            lock_cnt_q <= 18'h00000;
            qual_cnt_q <= 7'h00;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            lock_cnt_q <= lock_cnt_d;
            qual_cnt_q <= qual_cnt_d;
        end
    end

    // Mode and drain length are captured at IDLE so later changes cannot upset entry
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            halt_sel_q <= 1'b0;
            halving_q  <= 1'b0;
        end else if (idle_go) begin
            halt_sel_q <= low_power_ctrl_word_i != `LPSS_MODE_STANDBY;
            halving_q  <= input_clock_halving_i;
        end
    end

    // Clock and power controls, all registered from the next state
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            sys_en_q    <= 1'b1;
            core_en_q   <= 1'b1;
            periph_en_q <= 1'b1;
            xclk_en_q   <= 1'b1;
            pll_en_q    <= 1'b1;
            osc_en_q    <= 1'b1;
            resume_q    <= 1'b0;
            isr_q       <= 1'b0;
            stby_q      <= 1'b0;
            halt_q      <= 1'b0;
        end else begin
            sys_en_q    <= clk_run_d;
            core_en_q   <= clk_run_d;
            periph_en_q <= clk_run_d;
            xclk_en_q   <= (state_d == LPSS_DRAIN) ? (cnt_d < `LPSS_XCLK_CYCLES) : clk_run_d;
            pll_en_q    <= !pll_off_d;
            osc_en_q    <= !(state_d == LPSS_HALT && crystal_source_i);
            resume_q    <= resume_go;
            isr_q       <= resume_go && wake_int_enable_i;
            stby_q      <= state_d == LPSS_STANDBY;
            halt_q      <= state_d == LPSS_HALT;
        end
    end

    assign system_clock_en_o          = sys_en_q;
    assign core_clock_en_o            = core_en_q;
    assign periph_clock_en_o          = periph_en_q;
    assign external_clock_output_en_o = xclk_en_q;
    assign pll_power_en_o             = pll_en_q;
    assign osc_enable_o               = osc_en_q;
    assign resume_exec_o              = resume_q;
    assign wake_isr_req_o             = isr_q;
    assign standby_o                  = stby_q;
    assign halt_o                     = halt_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    standby_entry_a: assert property (idle_go && low_power_ctrl_word_i == `LPSS_MODE_STANDBY
                                      |=> state_q == LPSS_DRAIN)
        else $error("standby entry not started");
    drain_short_a: assert property (idle_go && !input_clock_halving_i |-> ##32 sys_en_q ##1 !sys_en_q)
        else $error("short drain length wrong");
    drain_long_a: assert property (idle_go && input_clock_halving_i |-> ##64 sys_en_q ##1 !sys_en_q)
        else $error("long drain length wrong");
    xclk_low_a: assert property (idle_go |-> ##32 xclk_en_q ##1 !xclk_en_q)
        else $error("external clock low time wrong");
    standby_gate_a: assert property (state_q == LPSS_STANDBY |-> !periph_en_q && pll_en_q)
        else $error("standby clock gating wrong");
    halt_off_a: assert property (state_q == LPSS_HALT |-> !core_en_q && !periph_en_q && !pll_en_q)
        else $error("halt did not stop clocks");
    halt_osc_a: assert property (state_q == LPSS_HALT && $past(state_q) == LPSS_HALT && crystal_source_i
                                 && $past(crystal_source_i) |-> !osc_en_q)
        else $error("oscillator running in halt");
    halt_wake_a: assert property (state_q == LPSS_HALT && halt_pin_fall
                                  |=> osc_en_q && state_q == LPSS_OSC_WAIT)
        else $error("halt wake did not restart oscillator");
    qual_reject_a: assert property (state_q == LPSS_STANDBY && !qual_hit |=> state_q == LPSS_STANDBY)
        else $error("short wake pulse accepted");
    lock_hold_a: assert property (state_q == LPSS_LOCK && lock_cnt_q != 18'h00000
                                  |=> state_q == LPSS_LOCK && !core_en_q)
        else $error("lock wait cut short");
    stby_latency_a: assert property (state_q == LPSS_STANDBY && qual_hit |-> ##[1:RES_MAX_STBY] resume_q)
        else $error("standby wake latency exceeded");
    halt_latency_a: assert property (lock_done |-> ##[1:RES_MAX_HALT] resume_q ##0 core_en_q)
        else $error("halt resume latency exceeded");
    wake_isr_a: assert property (resume_q |-> isr_q == $past(wake_int_enable_i))
        else $error("wake interrupt request mismatch");

    standby_cycle_c: cover property (state_q == LPSS_STANDBY ##[1:200] resume_q);
    halt_cycle_c: cover property (state_q == LPSS_HALT ##[1:1000] state_q == LPSS_LOCK);
    isr_c: cover property (isr_q);
    long_drain_c: cover property (idle_go && input_clock_halving_i);

endmodule

`default_nettype wire

// ### bench/lpss_wake_src.sv
// Wake source model: standby wake pulse, halt wake pin, reset pin and oscillator
`timescale 1ns/10ps
`default_nettype none
module lpss_wake_src (
    input  wire logic       clock_i,
    input  wire logic       start_i,
    input  wire logic [1:0] kind_i,
    input  wire logic [7:0] len_i,
    input  wire logic       osc_enable_i,
    output logic            standby_wake_n_o,
    output logic            halt_wake_pin_o,
    output logic            external_reset_pin_n_o,
    output logic            osc_stable_o
);
    int         left   = 0;
    int         up     = 0;
    logic       act    = 1'b0;
    logic       stable = 1'b1;
    logic [1:0] kind   = 2'h0;
    // Oscillator needs a few cycles after enable before it is stable
    always @(posedge clock_i) begin
        up <= osc_enable_i ? up + 1 : 0;
        stable <= osc_enable_i && (up >= 5);
    end
    assign osc_stable_o = stable;
    // Halt wakes hold until stable plus 2 or 8 cycles; standby holds len cycles
    always @(posedge clock_i) begin
        if (start_i) begin
            act <= 1'b1;
            kind <= kind_i;
            left <= (kind_i == 2'h0) ? int'(len_i) : ((kind_i == 2'h1) ? 2 : 8);
        end else if (act && (kind == 2'h0 || osc_stable_o)) begin
            left <= left - 1;
            if (left <= 1) act <= 1'b0;
        end
    end
    // Lines have pull-ups, so released pins read high
    assign standby_wake_n_o       = !(act && kind == 2'h0);
    assign halt_wake_pin_o        = !(act && kind == 2'h1);
    assign external_reset_pin_n_o = !(act && kind == 2'h2);
endmodule
`default_nettype wire

// ### bench/low_power_standby_halt_sequencer_tb_top.sv
// Testbench for the low-power standby/halt sequencer
`timescale 1ns/10ps
`default_nettype none
module low_power_standby_halt_sequencer_tb_top;
    localparam int LOCK = 16;
    logic clock_i = 1'b0, resetn_i = 1'b0, idle_exec_i = 1'b0, input_clock_halving_i = 1'b0;
    logic [1:0] low_power_ctrl_word_i = 2'h0, kind = 2'h0;
    logic [5:0] standby_wake_qual_count_i = 6'h00;
    logic standby_qual_en_i = 1'b0, crystal_source_i = 1'b0, wake_int_enable_i = 1'b0, start = 1'b0;
    logic [7:0] len = 8'h00;
    logic [31:0] rnd;
    wire logic swn, hwp, rpn, ost, sys, core, per, xck, pll, osc, res, isr, sb, hl;
    int bad_count = 0, check_count = 0, n, thr;
    int exp_isr[$]; // Rule model: one expected interrupt flag per accepted wake
    always #25 clock_i = !clock_i;
    lpss_sequencer #(.LOCK_CYCLES(LOCK)) DUT (.clock_i(clock_i), .resetn_i(resetn_i),
        .idle_exec_i(idle_exec_i), .low_power_ctrl_word_i(low_power_ctrl_word_i),
        .input_clock_halving_i(input_clock_halving_i), .standby_wake_qual_count_i(standby_wake_qual_count_i),
        .standby_qual_en_i(standby_qual_en_i), .crystal_source_i(crystal_source_i),
        .wake_int_enable_i(wake_int_enable_i), .standby_wake_n_i(swn), .halt_wake_pin_i(hwp),
        .external_reset_pin_n_i(rpn), .osc_stable_i(ost), .system_clock_en_o(sys), .core_clock_en_o(core),
        .periph_clock_en_o(per), .external_clock_output_en_o(xck), .pll_power_en_o(pll), .osc_enable_o(osc),
        .resume_exec_o(res), .wake_isr_req_o(isr), .standby_o(sb), .halt_o(hl));
    lpss_wake_src src (.clock_i(clock_i), .start_i(start), .kind_i(kind), .len_i(len), .osc_enable_i(osc),
        .standby_wake_n_o(swn), .halt_wake_pin_o(hwp), .external_reset_pin_n_o(rpn), .osc_stable_o(ost));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // Inputs change by NBA at the edge; outputs read here are what this edge samples
    task automatic step();
        @(posedge clock_i);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Idle request, then the drain and clock-output timing edge by edge
    task automatic enter(input logic [1:0] mode, input logic halv);
        int d;
        d = halv ? 64 : 32;
        low_power_ctrl_word_i <= mode;
        input_clock_halving_i <= halv;
        idle_exec_i <= 1'b1;
        @(posedge clock_i);
        idle_exec_i <= 1'b0;
        for (int k = 1; k <= d + 1; k++) begin
            step();
            if (k == 32) chk(xck, 1, "clock out dropped early");
            if (k == 33) chk(xck, 0, "clock out still running");
            if (k == d) chk(sys, 1, "drain cut short");
        end
        chk(sys, 0, "system clock not stopped");
    endtask
    task automatic pulse(input logic [1:0] k, input int l);
        start <= 1'b1;
        kind <= k;
        len <= l[7:0];
        step();
        start <= 1'b0;
    endtask
    // Bounded wait for the resume pulse; the interrupt follows the enable
    task automatic wait_res(input int lim);
        n = 0;
        while (res !== 1'b1 && n < lim) begin
            step();
            n++;
        end
        chk(res, 1, "no resume");
        chk(isr, exp_isr.pop_front(), "wake interrupt wrong");
    endtask
    // Watchdog far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        summarize();
    end
    initial begin
        rnd = 32'h00018393;
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        step();
        low_power_ctrl_word_i <= 2'h0;
        idle_exec_i <= 1'b1;
        step();
        idle_exec_i <= 1'b0;
        repeat (70) step();
        chk({sys, sb, hl}, 3'h4, "plain idle acted");
        $display("test plain_idle done");
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            standby_qual_en_i <= i[0];
            standby_wake_qual_count_i <= {3'h0, rnd[2:0]} + 6'h01;
            wake_int_enable_i <= rnd[3];
            thr = (i == 1) ? 3 + int'(rnd[2:0]) : 3;
            enter(2'h1, i[0]);
            chk({sb, per, pll}, 3'h5, "standby clocks wrong");
            pulse(2'h0, thr - 1);
            repeat (thr + 12) step();
            chk(sb, 1, "short wake accepted");
            exp_isr.push_back(int'(rnd[3]));
            pulse(2'h0, thr + 1);
            wait_res(100 + thr + 1);
            chk(n >= thr, 1, "wake before width");
            chk({sys, per, sb}, 3'h6, "standby not left");
            $display("test standby_%0d done", i);
        end
        for (int i = 1; i < 3; i++) begin
            rnd = lfsr(rnd);
            wake_int_enable_i <= rnd[3];
            crystal_source_i <= (i == 1);
            enter(2'h1 + i[1:0], i[0]);
            chk({hl, core, per, pll}, 4'h8, "halt clocks wrong");
            chk(osc, i != 1, "oscillator state wrong");
            exp_isr.push_back(int'(rnd[3]));
            pulse(i[1:0], 0);
            n = 0;
            while (ost !== 1'b1 && n < 100) begin
                step();
                n++;
            end
            chk({osc, ost}, 2'h3, "oscillator not restarted");
            wait_res(LOCK + 45);
            chk(n >= LOCK, 1, "lock wait too short");
            chk({core, per, pll, hl}, 4'hE, "halt not left");
            $display("test halt_%0d done", i);
        end
        summarize();
    end
endmodule
`default_nettype wire
